// [dac_serial_write_scan.sv]
// Functional notes
// [RULE1] 24-bit frame, MSB first on rising clock
// [RULE2] Each later bit on next rising edge
// [RULE3] Address byte first, then 16-bit data
// [RULE4] Host sends all 24 bits before load
// [RULE5] Shifting continues whatever the load level
// [RULE6] Load rising edge always commits frame; code counts it but drops the frame when the buffer is full
// [RULE7] Shift register cleared on reset; code clears it only on sclk edges, after a two-flop reset synchroniser
// [RULE8] Host keeps serial clock within maximum rate
// [RULE9] Host writes configuration before output codes
// [RULE10] Host writes calibration, optionally per channel
// [RULE11] One calibration set per scan allowed
// [RULE12] Host splits each channel slot in phases
// [RULE13] Host samples at least the minimum time
// [RULE14] Host reserves hold settling within sampling
// [RULE15] Host lowers switch enable before update
// [RULE16] Host raises enable after load and settling
`timescale 1ns/10ps
`include "dac_spi_regs.svh"

module dac_serial_write_scan #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // Serial link
  input  wire logic                   sclk,
  input  wire logic                   serialIn,
  input  wire logic                   loadStrobe,
  // Committed write stream
  output logic                        writeValid,
  input  wire logic                   writeReady,
  output logic      [`ADDR_BITS-1:0]  writeAddr,
  output logic      [`DATA_BITS-1:0]  writeData,
  // Register readback
  input  wire logic [`ADDR_BITS-1:0]  readAddr,
  output logic      [`DATA_BITS-1:0]  readData,
  // Status
  output logic      [15:0]            commitCount,
  output logic                        frameDropped
);

  localparam int REG_COUNT = 1 << `ADDR_BITS;

  // ---------------- Link clock domain ----------------

  logic                    linkRstMeta_q;
  logic                    linkRstn_q;
  logic [`FRAME_BITS-1:0]  shift_q, shift_d;
  logic [`BITCNT_BITS-1:0] bitCnt_q, bitCnt_d;
  logic                    frameFull_q, frameFull_d;

  // Reset brought onto the link clock; the serial clock only runs in frames
  always_ff @(posedge sclk) begin
    linkRstMeta_q <= rstn;
    linkRstn_q    <= linkRstMeta_q;
  end

  // Shift in MSB first, ignoring the load level entirely
  always_comb begin
    shift_d     = {shift_q[`FRAME_BITS-2:0], serialIn};  // RULE1 RULE2 RULE5
    bitCnt_d    = (bitCnt_q == `BITCNT_LAST) ? `BITCNT_RESET
                                             : bitCnt_q + 1'b1;
    frameFull_d = (bitCnt_q == `BITCNT_LAST);
  end

  always_ff @(posedge sclk) begin
    if (!linkRstn_q) begin
      shift_q     <= `SHIFT_RESET;  // RULE7
      bitCnt_q    <= `BITCNT_RESET;
      frameFull_q <= 1'b0;
    end else begin
      shift_q     <= shift_d;
      bitCnt_q    <= bitCnt_d;
      frameFull_q <= frameFull_d;
    end
  end

  // ---------------- System clock domain ----------------

  logic                        loadMeta_q;
  logic                        loadSync_q;
  logic                        loadPrev_q;
  logic                        loadRise;
  dac_spi_pkg::commit_state_t  state_q, state_d;
  logic [`FRAME_BITS-1:0]      capture_q, capture_d;
  logic [`FRAME_BITS-1:0]      fifoOutData;
  logic                        fifoInValid;
  logic                        fifoInReady;
  logic [15:0]                 commitCount_q, commitCount_d;
  logic                        dropped_q, dropped_d;
  logic                        drainFire;

  // Load pin passes two flops before any edge detection
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      loadMeta_q <= 1'b0;
      loadSync_q <= 1'b0;
      loadPrev_q <= 1'b0;
    end else begin
      loadMeta_q <= loadStrobe;
      loadSync_q <= loadMeta_q;
      loadPrev_q <= loadSync_q;
    end
  end

  assign loadRise = loadSync_q && !loadPrev_q;

  // The shift register is quiet once the host stops the serial clock, so the word is
  // taken one settle cycle after the synchronised edge.
  // A load with fewer than 24 bits still commits what is held.
  always_comb begin
    state_d       = state_q;
    capture_d     = capture_q;
    fifoInValid   = 1'b0;
    commitCount_d = commitCount_q;
    dropped_d     = dropped_q;
    unique case (state_q)
      dac_spi_pkg::CommitIdle: begin
        if (loadRise) begin
          state_d = dac_spi_pkg::CommitSettle;  // RULE6 RULE4
        end
      end
      dac_spi_pkg::CommitSettle: begin
        capture_d = shift_q;
        state_d   = dac_spi_pkg::CommitPush;
      end
      dac_spi_pkg::CommitPush: begin
        // Committed without condition; a full buffer loses the frame
        fifoInValid   = 1'b1;  // RULE6
        commitCount_d = commitCount_q + 1'b1;
        if (!fifoInReady) begin
          dropped_d = 1'b1;
        end
        state_d = loadRise ? dac_spi_pkg::CommitSettle
                           : dac_spi_pkg::CommitIdle;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q       <= dac_spi_pkg::CommitIdle;
      capture_q     <= `SHIFT_RESET;
      commitCount_q <= `COUNT_RESET;
      dropped_q     <= 1'b0;
    end else begin
      state_q       <= state_d;
      capture_q     <= capture_d;
      commitCount_q <= commitCount_d;
      dropped_q     <= dropped_d;
    end
  end

  frame_fifo #(
    .WIDTH (`FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_frame_fifo (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (capture_q),
    .outValid (writeValid),
    .outReady (writeReady),
    .outData  (fifoOutData)
  );

  // Address byte leads, data word trails
  assign writeAddr = fifoOutData[`ADDR_MSB:`ADDR_LSB];  // RULE3
  assign writeData = fifoOutData[`DATA_MSB:`DATA_LSB];  // RULE3
  assign drainFire = writeValid && writeReady;

  // Addressed register bank, written as frames leave the buffer
  logic [`DATA_BITS-1:0] regBank [REG_COUNT];
  logic [`DATA_BITS-1:0] readData_q, readData_d;

  always_ff @(posedge sys_clk) begin
    if (drainFire) begin
      regBank[writeAddr] <= writeData;
    end
  end

  // Readback is registered; unwritten entries are unknown until written
  always_comb begin
    readData_d = regBank[readAddr];
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      readData_q <= `DATA_RESET;
    end else begin
      readData_q <= readData_d;
    end
  end

  assign readData     = readData_q;
  assign commitCount  = commitCount_q;
  assign frameDropped = dropped_q;

endmodule : dac_serial_write_scan

// [dac_spi_regs.svh]
`ifndef DAC_SPI_REGS_SVH
`define DAC_SPI_REGS_SVH

// Serial frame layout
`define FRAME_BITS      24
`define ADDR_BITS       8
`define DATA_BITS       16
`define ADDR_MSB        23
`define ADDR_LSB        16
`define DATA_MSB        15
`define DATA_LSB        0

// Reset values
`define SHIFT_RESET     24'h000000
`define DATA_RESET      16'h0000
`define COUNT_RESET     16'h0000

// Frame buffer depth
`define FIFO_DEPTH      32

// Bit counter width and its reset
`define BITCNT_BITS     5
`define BITCNT_RESET    5'h00
`define BITCNT_LAST     5'h17

// Fastest serial clock the port is built for, in MHz
`define SCLK_MAX_MHZ    31

`endif

// [dac_spi_pkg.sv]
package dac_spi_pkg;

  // Commit sequencer in the system clock domain
  typedef enum logic [1:0] {
    CommitIdle,
    CommitSettle,
    CommitPush
  } commit_state_t;

endpackage : dac_spi_pkg

// [frame_fifo.sv]
`timescale 1ns/10ps
`include "dac_spi_regs.svh"

module frame_fifo #(
  parameter int WIDTH = `FRAME_BITS,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d;
  logic [PW-1:0]    rdPtr_q, rdPtr_d;
  logic [PW:0]      count_q, count_d;
  logic             doWrite;
  logic             doRead;

  // Honest full and empty come straight from the occupancy count
  assign inReady  = (count_q != (PW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  // Pointer and count next values
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (doWrite) begin
      wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (doRead) begin
      rdPtr_d = (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (doWrite && !doRead) begin
      count_d = count_q + 1'b1;
    end else if (doRead && !doWrite) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule : frame_fifo

// [dac_serial_write_scan_assertions.sv]
`timescale 1ns/10ps
module dac_serial_write_scan_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Serial link
  input wire logic        sclk,
  input wire logic        serialIn,
  input wire logic        loadStrobe,
  // Stream, readback, status
  input wire logic        writeValid,
  input wire logic        writeReady,
  input wire logic [7:0]  writeAddr,
  input wire logic [15:0] writeData,
  input wire logic [7:0]  readAddr,
  input wire logic [15:0] readData,
  input wire logic [15:0] commitCount,
  input wire logic        frameDropped
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Reset itself is watched, so this one is never disabled
  property p_rstQuiet; disable iff (1'b0) !rstn |=> !writeValid &&
    commitCount == 16'h0000 && !frameDropped; endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("busy in reset");
  property p_loadCnt; $rose(loadStrobe) |-> ##[2:6] $changed(commitCount);
  endproperty
  a_loadCnt: assert property (p_loadCnt) else $error("no count");
  property p_cntStep; $changed(commitCount) |->
    commitCount == $past(commitCount) + 16'h0001; endproperty
  a_cntStep: assert property (p_cntStep) else $error("bad step");
  property p_loadValid; $rose(loadStrobe) |-> ##[3:6] writeValid; endproperty
  a_loadValid: assert property (p_loadValid) else $error("no word");
  property p_hold; writeValid && !writeReady |=> writeValid &&
    $stable(writeAddr) && $stable(writeData); endproperty
  a_hold: assert property (p_hold) else $error("head moved");
  property p_sticky; frameDropped |=> frameDropped; endproperty
  a_sticky: assert property (p_sticky) else $error("drop lost");
  property p_dropFull; $rose(frameDropped) |-> writeValid; endproperty
  a_dropFull: assert property (p_dropFull) else $error("drop, empty");
  // Strobe low long enough means every commit has landed
  property p_quiet; !loadStrobe [*8] |=> $stable(commitCount); endproperty
  a_quiet: assert property (p_quiet) else $error("stray count");
  property p_cause; $rose(writeValid) |->
    commitCount != $past(commitCount, 2); endproperty
  a_cause: assert property (p_cause) else $error("stray word");
  c_drop: cover property ($rose(frameDropped));
  c_b2b: cover property (writeValid && writeReady [*2]);
  c_load: cover property ($rose(loadStrobe));
endmodule : dac_serial_write_scan_assertions

bind dac_serial_write_scan dac_serial_write_scan_assertions u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .sclk(sclk), .serialIn(serialIn),
  .loadStrobe(loadStrobe), .writeValid(writeValid),
  .writeReady(writeReady), .writeAddr(writeAddr), .writeData(writeData),
  .readAddr(readAddr), .readData(readData), .commitCount(commitCount),
  .frameDropped(frameDropped));

// [host_link_model.sv]
`timescale 1ns/10ps
module host_link_model (
  // Serial link into the port
  output logic sclk,
  output logic serialIn,
  output logic loadStrobe,
  // Output multiplexer control
  output logic       switchEnable,
  output logic [2:0] channelSelect
);
  // Link clock rests low between frames
  initial begin
    sclk = 1'b0;
    serialIn = 1'b1;
    loadStrobe = 1'b0;
    switchEnable = 1'b0;
    channelSelect = 3'h0;
  end
  // Slot opens with the switch off so a new code cannot disturb holds
  task automatic openSlot(input logic [2:0] ch);
    switchEnable = 1'b0;
    channelSelect = ch;
  endtask : openSlot
  // Switch closes only after load and settling, and opens before next code
  task automatic closeSlot(input int settleNs, input int sampleNs);
    #(settleNs) switchEnable = 1'b1;
    #(sampleNs) switchEnable = 1'b0;
  endtask : closeSlot
  // MSB first, one bit per 64 ns period, well under the top rate
  task automatic shift(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = v[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    serialIn = ~serialIn; // Released line must not look valid
  endtask : shift
  // Strobe edge comes only once the clock has stopped
  task automatic raise();
    #8 loadStrobe = 1'b1;
  endtask : raise
  task automatic drop();
    #24 loadStrobe = 1'b0;
    #24;
  endtask : drop
endmodule : host_link_model

// [dac_serial_write_scan_tb.sv]
`timescale 1ns/10ps
module dac_serial_write_scan_tb;
  localparam int DEPTH = 4;
  // Port wiring and scoreboard
  logic        sys_clk, rstn, writeReady, writeValid, frameDropped;
  logic        sclk, serialIn, loadStrobe, randReady;
  logic [7:0]  readAddr, writeAddr;
  logic [15:0] writeData, readData, commitCount, nCommit;
  logic [23:0] sr, lastF;
  logic [23:0] expQ[$];
  int          occ, n_mismatch, checks_done;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  host_link_model u_host (.sclk(sclk), .serialIn(serialIn),
    .loadStrobe(loadStrobe), .switchEnable(), .channelSelect());
  dac_serial_write_scan #(.FIFO_DEPTH(DEPTH)) u_dut (.sys_clk(sys_clk),
    .rstn(rstn), .sclk(sclk), .serialIn(serialIn), .loadStrobe(loadStrobe),
    .writeValid(writeValid), .writeReady(writeReady),
    .writeAddr(writeAddr), .writeData(writeData), .readAddr(readAddr),
    .readData(readData), .commitCount(commitCount),
    .frameDropped(frameDropped));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic checkFrame(logic [23:0] got, logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t frame %h want %h", $time, got, exp);
    end
  endtask : checkFrame
  task automatic checkVal(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h want %h", $time, got, exp);
    end
  endtask : checkVal
  // Short bursts keep the older bits, shifted up
  function automatic logic [23:0] shiftIn(logic [23:0] s, v, int n);
    return (s << n) | (v & ((24'h000001 << n) - 24'h000001));
  endfunction : shiftIn
  task automatic send(logic [23:0] v, int n);
    u_host.shift(v, n);
    sr = shiftIn(sr, v, n);
  endtask : send
  // A full buffer loses the frame but the commit still counts
  task automatic pushExp();
    nCommit++;
    if (occ < DEPTH) begin
      expQ.push_back(sr);
      occ++;
    end
  endtask : pushExp
  task automatic commit();
    u_host.raise();
    pushExp();
    u_host.drop();
  endtask : commit
  task automatic drain();
    for (int i = 0; i < 400 && occ > 0; i++) @(posedge sys_clk);
    checkVal(16'(occ), 16'h0000);
  endtask : drain
  // Every accepted word must match the oldest expected frame
  always @(posedge sys_clk) begin
    if (rstn === 1'b1 && writeValid === 1'b1 && writeReady === 1'b1) begin
      lastF = (expQ.size() > 0) ? expQ.pop_front() : 24'hxxxxxx;
      checkFrame({writeAddr, writeData}, lastF);
      occ--;
    end
  end
  // Random stalls on the stream side
  always @(negedge sys_clk) begin
    if (randReady) writeReady <= 1'($urandom_range(0, 1));
  end
  initial begin
    #200000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog", $time);
    close_out();
  end
  initial begin
    rstn = 1'b0;
    writeReady = 1'b1;
    randReady = 1'b0;
    readAddr = 8'h00;
    sr = 24'h000000;
    nCommit = 16'h0000;
    void'($urandom(26189));
    // Ones shifted in reset must be wiped; link needs edges in reset
    fork
      u_host.shift(24'hffffff, 4);
    join_none
    repeat (70) @(negedge sys_clk);
    rstn = 1'b1;
    send(24'h000000, 3);
    commit();
    randReady = 1'b1;
    // Setup frames lead the codes; their addresses are arbitrary
    send({8'h55, 16'($urandom)}, 24);
    commit();
    send({8'h09, 16'($urandom)}, 24);
    commit();
    for (int ch = 0; ch < 8; ch++) begin
      u_host.openSlot(3'(ch));
      send(24'($urandom), 24);
      commit();
      u_host.closeSlot(200, 300);
    end
    send(24'($urandom), 8);
    commit();
    // Bits clocked while the strobe sits high still land
    u_host.raise();
    pushExp();
    send(24'($urandom), 24);
    u_host.drop();
    commit();
    randReady = 1'b0;
    @(negedge sys_clk) writeReady = 1'b1;
    drain();
    @(negedge sys_clk) writeReady = 1'b0;
    repeat (DEPTH + 2) begin
      send(24'($urandom), 24);
      commit();
    end
    checkVal({15'h0000, frameDropped}, 16'h0001);
    @(negedge sys_clk) writeReady = 1'b1;
    drain();
    checkVal(commitCount, nCommit);
    @(negedge sys_clk) readAddr = lastF[23:16];
    repeat (2) @(negedge sys_clk);
    checkVal(readData, lastF[15:0]);
    close_out();
  end
endmodule : dac_serial_write_scan_tb
